/* bench/spd_slave_model.sv */
/*
  behavioural serial slave facing the core's master pins.
  assumes mode 0, msb first; frame k is answered with {8'hc3, k}.
*/
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// slave model
// ****************************************
module spd_slave_model (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic [15:0] got,
  output logic [7:0] frames
);
  logic [15:0] sh;
  logic [4:0] nb;
  initial begin
    miso = 1'b0;
    got = 16'h0000;
    frames = 8'h00;
    sh = 16'h0000;
    nb = 5'h00;
  end
  // first bit must stand before the first rising edge
  always @(negedge ss_n) begin
    sh = {8'hc3, frames};
    miso = sh[15];
    nb = 5'h00;
  end
  always @(posedge sck) if (!ss_n) begin
    got = {got[14:0], mosi};
    nb = nb + 5'h01;
  end
  always @(negedge sck) if (!ss_n) begin
    sh = {sh[14:0], 1'b0};
    miso = sh[15];
  end
  // released line has no pull: flip it so a stale level never passes
  always @(posedge ss_n) begin
    miso = ~miso;
    if (nb == 5'h10) frames = frames + 8'h01;
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
/*
  self-checking bench of spd_core as link master, then as link slave.
  assumes spd_slave_model on the link and AXI4-Lite driven from here.
*/
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench
// ****************************************
module tb;
  import spd_pkg::*;
  localparam logic [5:0] A_CT = {IDX_CTRL, 2'b00};
  localparam logic [5:0] A_ST = {IDX_STAT, 2'b00};
  localparam logic [5:0] A_HI = {IDX_HI, 2'b00};
  localparam logic [5:0] A_LO = {IDX_LO, 2'b00};
  localparam logic [5:0] A_IS = {IDX_ISTAT, 2'b00};
  localparam logic [5:0] A_IM = {IDX_IMASK, 2'b00};
  localparam logic [15:0] S_WORD = 16'h9617;
  logic bsck, bmosi, bss;
  logic sys_clk, rst_n, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, irq, miso_m;
  logic [5:0] awa, ara;
  logic [31:0] wd, rdt;
  logic [1:0] br, rr, resp;
  logic [7:0] rdat, f, frames;
  logic [15:0] got;
  spd_link_in_t li;
  spd_link_out_t lo;
  int n_mismatch = 0;
  int compares = 0;
  assign li = {lo.sck_oe ? lo.sck_o : bsck, lo.mosi_oe ? lo.mosi_o : bmosi,
    lo.miso_oe ? lo.miso_o : miso_m, lo.ss_n_oe ? lo.ss_n_o : bss};
  spd_core uut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .link_in(li), .link_out(lo),
    .irq(irq));
  spd_slave_model slave (.sck(li.sck), .ss_n(li.ss_n), .mosi(li.mosi), .miso(miso_m),
    .got(got), .frames(frames));
  task automatic summarize;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic to;
    n_mismatch++;
    $display("FAIL %0t wait ran out", $time);
    summarize();
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (n > 500) to();
    end while (!bv);
    resp = br;
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arr) arv <= 1'b0;
      if (n > 500) to();
    end while (!rv);
    rdat = rdt[7:0];
    resp = rr;
    rry <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk({8'h00, rdat & m}, {8'h00, e});
  endtask
  // arms the low write with a status read that saw room
  task automatic send(input logic [7:0] d);
    int n;
    n = 0;
    do begin
      rd(A_ST);
      n++;
      if (n > 100) to();
    end while (rdat[SB_TEF] !== 1'b1);
    wr(A_LO, d);
  endtask
  task automatic waitf(input logic [7:0] t);
    int n;
    n = 0;
    while (frames !== t) begin
      @(posedge sys_clk);
      n++;
      if (n > 3000) to();
    end
  endtask
  task automatic t_reset;
    rdc(A_HI, 8'hff, 8'h00);
    rdc(A_LO, 8'hff, 8'h00);
    rdc(A_ST, 8'h0f, 8'h02);
    rd(6'h3c);
    chk({14'h0000, resp}, {14'h0000, RESP_SLVERR});
    wr(6'h3c, 8'h00);
    chk({14'h0000, resp}, {14'h0000, RESP_SLVERR});
    wr(A_HI, 8'h5a);
    wr(A_HI, 8'ha5);
    chk({14'h0000, resp}, {14'h0000, RESP_OKAY});
    rdc(A_ST, 8'h02, 8'h02);
  endtask
  task automatic t_frame;
    wr(A_CT, 8'h03);
    wr(A_IM, 8'h00);
    f = frames;
    send(8'h3c);
    waitf(f + 8'h01);
    chk(got, 16'ha53c);
    rdc(A_ST, 8'h01, 8'h01);
    chk({15'h0000, irq}, 16'h0000);
    wr(A_IM, 8'h01);
    rdc(A_HI, 8'hff, 8'hc3);
    chk({15'h0000, irq}, 16'h0001);
    rdc(A_LO, 8'hff, f);
    rdc(A_ST, 8'h01, 8'h00);
    wr(A_IS, 8'h07);
    rd(A_ST);
    chk({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_held;
    f = frames;
    send(8'h01);
    send(8'h02);
    waitf(f + 8'h02);
    chk(got, 16'ha502);
    rdc(A_ST, 8'h07, 8'h07);
    rdc(A_LO, 8'hff, f);
    rdc(A_ST, 8'h05, 8'h01);
    rdc(A_LO, 8'hff, f + 8'h01);
  endtask
  task automatic t_drop;
    f = frames;
    send(8'h11);
    send(8'h12);
    send(8'h13);
    waitf(f + 8'h03);
    rdc(A_IS, 8'h04, 8'h04);
    rdc(A_ST, 8'h01, 8'h01);
    rdc(A_LO, 8'hff, f);
    rdc(A_ST, 8'h05, 8'h01);
    rdc(A_LO, 8'hff, f + 8'h02);
  endtask
  // a low write with no status read in between must be dropped
  task automatic t_unarmed;
    f = frames;
    send(8'h21);
    wr(A_LO, 8'h22);
    send(8'h23);
    waitf(f + 8'h02);
    chk(got, 16'ha523);
    rdc(A_ST, 8'h08, 8'h00);
  endtask
  // bench plays the far master, mode 0, four clocks per half period
  task automatic t_slave;
    logic [15:0] m;
    wr(A_CT, 8'h01);
    send(8'h44);
    bss <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      bmosi <= S_WORD[i];
      repeat (4) @(posedge sys_clk);
      m = {m[14:0], lo.miso_o};
      bsck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      bsck <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    bss <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(m, 16'ha544);
    rd(A_ST);
    rd(A_LO);
    rdc(A_HI, 8'hff, S_WORD[15:8]);
    rd(A_ST);
    rdc(A_LO, 8'hff, S_WORD[7:0]);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    rst_n = 1'b0;
    {awv, wv, bry, arv, rry} = 5'h00;
    {bsck, bmosi, bss} = 3'h1;
    awa = 6'h00;
    ara = 6'h00;
    wd = 32'h00000000;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_frame();
    t_held();
    t_drop();
    t_unarmed();
    t_slave();
    summarize();
  end
endmodule
`default_nettype wire

/* hdl/spd_core.sv */
/*
  serial data register path with an AXI4-Lite register slave.
  assumes AXI on sys_clk and link pins from outside the clock domain.
*/
// Added by the designer: the AXI4-Lite interface to the registers.
// What this block does
// - data word as high and low bytes
// - read gives received, write gives transmit word
// - written word is queued for shifting out
// - master sends queued word after previous ends
// - transmit empty flag shows room for word
// - empty clears on low write after read
// - high byte writes never touch empty flag
// - first word moves in, full flag set
// - second word held, data register kept
// - serviced before third start: held moves in
// - third start first: held word discarded
`timescale 1ns/1ps
`default_nettype none
module spd_core (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire spd_pkg::spd_link_in_t link_in,
  output var spd_pkg::spd_link_out_t link_out,
  output logic irq
);
  import spd_pkg::*;

  // ****************************************
  // address decode
  // ****************************************
  // bit 4 marks a mapped word-aligned address
  function automatic logic [4:0] decode(input logic [5:0] addr);
    logic [3:0] idx;
    idx = addr[5:2];
    if (addr[1:0] != 2'h0) begin
      decode = 5'h00;
    end else if (idx == IDX_CTRL || idx == IDX_STAT) begin
      decode = {1'b1, idx};
    end else if (idx == IDX_HI || idx == IDX_LO) begin
      decode = {1'b1, idx};
    end else if (idx == IDX_ISTAT || idx == IDX_IMASK) begin
      decode = {1'b1, idx};
    end else begin
      decode = 5'h00;
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [5:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [4:0] wr_dec, rd_dec;
  logic wr_fire, rd_fire, wr_en;
  logic [7:0] rd_byte, stat_byte;
  logic ctrl_en, next_ctrl_en, ctrl_mst, next_ctrl_mst;
  logic [7:0] tx_hi, next_tx_hi;
  logic [15:0] tx_q, next_tx_q, rdr, next_rdr, held, next_held;
  logic held_valid, next_held_valid;
  logic tef, next_tef, tef_armed, next_tef_armed;
  logic rff, next_rff, rff_armed, next_rff_armed;
  logic [2:0] int_stat, next_int_stat, int_mask, next_int_mask, ev;
  logic next_irq, took_set, service, wr_lo, wr_hi;
  spd_evt_t evt;
  logic [15:0] eng_rx;

  assign wr_dec = decode(aw_addr);
  assign rd_dec = decode(s_axi_araddr);
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_en = wr_fire && wr_dec[4] && w_lane;
  assign wr_lo = wr_en && wr_dec[3:0] == IDX_LO;
  assign wr_hi = wr_en && wr_dec[3:0] == IDX_HI;
  // only a word actually queued counts as leaving the register
  assign took_set = evt.took && !tef;
  assign service = rd_fire && rd_dec == {1'b1, IDX_LO} && rff_armed && rff;

  // ****************************************
  // shift engine
  // ****************************************
  spd_shift u_shift (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(ctrl_en),
    .master(ctrl_mst),
    .start_req(!tef),
    .tx_word(tx_q),
    .link_in(link_in),
    .link_out(link_out),
    .evt(evt),
    .rx_word(eng_rx)
  );

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[SB_RFF] = rff;
    stat_byte[SB_TEF] = tef;
    stat_byte[SB_HELD] = held_valid;
    stat_byte[SB_BUSY] = evt.busy;
    if (rd_dec == {1'b1, IDX_CTRL}) begin
      rd_byte = {6'h00, ctrl_mst, ctrl_en};
    end else if (rd_dec == {1'b1, IDX_STAT}) begin
      rd_byte = stat_byte;
    end else if (rd_dec == {1'b1, IDX_HI}) begin
      rd_byte = rdr[15:8];
    end else if (rd_dec == {1'b1, IDX_LO}) begin
      rd_byte = rdr[7:0];
    end else if (rd_dec == {1'b1, IDX_ISTAT}) begin
      rd_byte = {5'h00, int_stat};
    end else if (rd_dec == {1'b1, IDX_IMASK}) begin
      rd_byte = {5'h00, int_mask};
    end else begin
      rd_byte = 8'h00;
    end
  end

  // ****************************************
  // bus channels
  // ****************************************
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_byte = w_byte;
    next_w_lane = w_lane;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_dec[4] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, rd_byte};
      next_rresp = rd_dec[4] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready = !next_w_full && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      aw_addr <= 6'h00;
      w_full <= 1'b0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ****************************************
  // data path and flags
  // ****************************************
  always_comb begin
    next_ctrl_en = ctrl_en;
    next_ctrl_mst = ctrl_mst;
    next_tx_hi = tx_hi;
    next_tx_q = tx_q;
    next_rdr = rdr;
    next_held = held;
    next_held_valid = held_valid;
    next_tef = tef;
    next_tef_armed = tef_armed;
    next_rff = rff;
    next_rff_armed = rff_armed;
    next_int_mask = int_mask;
    ev = 3'h0;
    if (wr_en && wr_dec[3:0] == IDX_CTRL) begin
      next_ctrl_en = w_byte[CT_EN];
      next_ctrl_mst = w_byte[CT_MST];
    end
    if (wr_en && wr_dec[3:0] == IDX_IMASK) begin
      next_int_mask = w_byte[2:0];
    end
    if (wr_hi) begin
      next_tx_hi = w_byte;
    end
    // an unarmed low write is dropped so a busy word is never corrupted
    if (wr_lo) begin
      next_tef_armed = 1'b0;
      if (tef && tef_armed) begin
        next_tx_q = {tx_hi, w_byte};
        next_tef = 1'b0;
      end
    end
    if (rd_fire && rd_dec == {1'b1, IDX_STAT}) begin
      if (tef) begin
        next_tef_armed = 1'b1;
      end
      if (rff) begin
        next_rff_armed = 1'b1;
      end
    end
    if (took_set) begin
      next_tef = 1'b1;
      ev[EV_TX] = 1'b1;
    end
    if (service) begin
      next_rff_armed = 1'b0;
      if (held_valid) begin
        next_rdr = held;
        next_held_valid = 1'b0;
      end else begin
        next_rff = 1'b0;
      end
    end
    // the start of the next frame discards the held word
    if (evt.start && held_valid && !service) begin
      next_held_valid = 1'b0;
      ev[EV_DROP] = 1'b1;
    end
    // a word landing in the clearing cycle still sets the flag
    if (evt.done) begin
      if (!rff || (service && !held_valid)) begin
        next_rdr = eng_rx;
        next_rff = 1'b1;
        ev[EV_RX] = 1'b1;
      end else begin
        next_held = eng_rx;
        next_held_valid = 1'b1;
      end
    end
    next_int_stat = int_stat | ev;
    if (wr_en && wr_dec[3:0] == IDX_ISTAT) begin
      next_int_stat = (int_stat & ~w_byte[2:0]) | ev;
    end
    next_irq = |(next_int_stat & next_int_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_en <= 1'b0;
      ctrl_mst <= 1'b0;
      tx_hi <= 8'h00;
      tx_q <= DATA_RST;
      rdr <= DATA_RST;
      held <= DATA_RST;
      held_valid <= 1'b0;
      tef <= 1'b1;
      tef_armed <= 1'b0;
      rff <= 1'b0;
      rff_armed <= 1'b0;
      int_stat <= 3'h0;
      int_mask <= 3'h0;
      irq <= 1'b0;
    end else begin
      ctrl_en <= next_ctrl_en;
      ctrl_mst <= next_ctrl_mst;
      tx_hi <= next_tx_hi;
      tx_q <= next_tx_q;
      rdr <= next_rdr;
      held <= next_held;
      held_valid <= next_held_valid;
      tef <= next_tef;
      tef_armed <= next_tef_armed;
      rff <= next_rff;
      rff_armed <= next_rff_armed;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      irq <= next_irq;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_reset_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> rdr == DATA_RST && tx_q == DATA_RST && tx_hi == 8'h00)
    else $error("data bytes not zero after reset");
  a_read_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_fire && rd_dec == {1'b1, IDX_LO}) |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(rdr[7:0]))
    else $error("low byte read does not return received data");
  a_queue_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_lo && tef && tef_armed) |=> tx_q == {$past(tx_hi), $past(w_byte)})
    else $error("written word not queued");
  a_tef_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    took_set |=> tef)
    else $error("empty flag not raised when word taken");
  a_tef_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_lo && tef && tef_armed) |=> !tef)
    else $error("empty flag kept after armed low write");
  a_tef_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(tef) |-> $past(wr_lo) && $past(tef_armed))
    else $error("empty flag cleared without armed low write");
  a_hi_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_hi && !took_set) |=> tef == $past(tef))
    else $error("high byte write changed empty flag");
  a_rx_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (evt.done && !rff) |=> rff && rdr == $past(eng_rx))
    else $error("received word not loaded");
  a_hold_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (evt.done && rff && !service) |=> held_valid && $stable(rdr))
    else $error("second word disturbed data register");
  a_held_move: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (service && held_valid && !evt.done) |=> rff && rdr == $past(held))
    else $error("held word not moved on service");
  a_held_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (evt.start && held_valid && !service) |=> !held_valid && $stable(rdr))
    else $error("held word survived a third start");
  a_rff_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (service && !held_valid && !evt.done) |=> !rff)
    else $error("full flag not cleared by service");
endmodule
`default_nettype wire

/* hdl/spd_shift.sv */
/*
  16-bit shift engine, mode 0, msb first, master or slave.
  assumes link pins arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module spd_shift (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic master,
  input wire logic start_req,
  input wire logic [15:0] tx_word,
  input wire spd_pkg::spd_link_in_t link_in,
  output var spd_pkg::spd_link_out_t link_out,
  output var spd_pkg::spd_evt_t evt,
  output logic [15:0] rx_word
);
  import spd_pkg::*;
  logic [3:0] sync1, sync2, prev;
  spd_state_t state, next_state;
  logic [2:0] div, next_div;
  logic [4:0] bits, next_bits;
  logic [15:0] shreg, next_shreg, next_rx;
  spd_link_out_t next_out;
  spd_evt_t next_evt;
  logic sck_s, mosi_s, miso_s, ss_s, sck_rise, sck_fall, ss_fall;

  assign {sck_s, mosi_s, miso_s, ss_s} = sync2;
  assign sck_rise = sck_s & ~prev[3];
  assign sck_fall = ~sck_s & prev[3];
  assign ss_fall = ~ss_s & prev[0];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_div = div;
    next_bits = bits;
    next_shreg = shreg;
    next_rx = rx_word;
    next_out = link_out;
    next_evt = '0;
    next_evt.busy = (state != ST_IDLE);
    next_out.sck_oe = enable & master;
    next_out.mosi_oe = enable & master;
    next_out.ss_n_oe = enable & master;
    if (!enable) begin
      next_out.miso_oe = 1'b0;
      next_out.ss_n_o = 1'b1;
      next_out.sck_o = 1'b0;
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          // master starts on any queued word without software help
          if ((master && start_req) || (!master && ss_fall)) begin
            next_shreg = tx_word;
            next_bits = 5'h00;
            next_div = 3'h0;
            next_out.mosi_o = tx_word[15];
            next_out.miso_o = tx_word[15];
            next_out.miso_oe = !master;
            next_out.ss_n_o = !master;
            next_out.sck_o = 1'b0;
            next_evt.took = 1'b1;
            next_evt.start = 1'b1;
            next_state = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (master) begin
            next_div = div + 3'h1;
            if (div == HALF_LAST) begin
              next_div = 3'h0;
              next_out.sck_o = ~link_out.sck_o;
              if (!link_out.sck_o) begin
                next_shreg = {shreg[14:0], miso_s};
                next_bits = bits + 5'h01;
              end else if (bits == WORD_BITS) begin
                next_rx = shreg;
                next_evt.done = 1'b1;
                next_state = ST_TAIL;
              end else begin
                next_out.mosi_o = shreg[15];
              end
            end
          end else if (ss_s) begin
            // select released early: the frame is dropped
            next_out.miso_oe = 1'b0;
            next_state = ST_IDLE;
          end else if (sck_rise) begin
            next_shreg = {shreg[14:0], mosi_s};
            next_bits = bits + 5'h01;
            if (bits == WORD_BITS - 5'h01) begin
              next_rx = {shreg[14:0], mosi_s};
              next_evt.done = 1'b1;
              next_state = ST_TAIL;
            end
          end else if (sck_fall) begin
            next_out.miso_o = shreg[15];
          end
        end
        ST_TAIL: begin
          if (master) begin
            next_div = div + 3'h1;
            if (div == HALF_LAST) begin
              next_out.ss_n_o = 1'b1;
              next_state = ST_IDLE;
            end
          end else if (ss_s) begin
            next_out.miso_oe = 1'b0;
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
      prev <= SYNC_RST;
      state <= ST_IDLE;
      div <= 3'h0;
      bits <= 5'h00;
      shreg <= DATA_RST;
      rx_word <= DATA_RST;
      link_out <= LINK_OUT_RST;
      evt <= '0;
    end else begin
      sync1 <= link_in;
      sync2 <= sync1;
      prev <= sync2;
      state <= next_state;
      div <= next_div;
      bits <= next_bits;
      shreg <= next_shreg;
      rx_word <= next_rx;
      link_out <= next_out;
      evt <= next_evt;
    end
  end

  a_master_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state == ST_IDLE && enable && master && start_req) |=> state == ST_SHIFT && !link_out.ss_n_o)
    else $error("master did not start a queued word");
endmodule
`default_nettype wire

/* inc/spd_pkg.sv */
/*
  shared constants and types of the serial data register path.
  assumes a 25 MHz system clock and a link clock of 320 ns period.
*/
`default_nettype none
package spd_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  // longest half period, rounded down
  localparam int HALF_CYC = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);
  localparam logic [4:0] WORD_BITS = 5'h10;
  // ****************************************
  // register map (index, byte address is four times it)
  // ****************************************
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_STAT = 4'h3;
  localparam logic [3:0] IDX_HI = 4'h4;
  localparam logic [3:0] IDX_LO = 4'h5;
  localparam logic [3:0] IDX_ISTAT = 4'h8;
  localparam logic [3:0] IDX_IMASK = 4'h9;
  localparam int CT_EN = 0;
  localparam int CT_MST = 1;
  localparam int SB_RFF = 0;
  localparam int SB_TEF = 1;
  localparam int SB_HELD = 2;
  localparam int SB_BUSY = 3;
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_DROP = 2;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] SYNC_RST = 4'h1;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_TAIL = 2'b11
  } spd_state_t;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spd_link_in_t;
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_n_o;
    logic ss_n_oe;
  } spd_link_out_t;
  localparam spd_link_out_t LINK_OUT_RST = 8'h02;
  typedef struct packed {
    logic took;
    logic start;
    logic done;
    logic busy;
  } spd_evt_t;
endpackage
`default_nettype wire
